// ===== pkg/memb_defines.svh
// Constants for the external memory bus block
`ifndef MEMB_DEFINES_SVH
`define MEMB_DEFINES_SVH

// =========================================
// Memory map
`define MEMB_ROM_LIMIT    16'h0800
`define MEMB_BOOT_ADDR    16'h000c
`define MEMB_ROM_AW       11

// =========================================
// Upper address port modes
`define MEMB_UP_IO        2'h0
`define MEMB_UP_NIBBLE    2'h1
`define MEMB_UP_FULL      2'h2

// =========================================
// Port line positions
`define MEMB_DM_BIT       4

`endif

// ===== pkg/memb_pkg.sv
// Types shared by the external memory bus block
`default_nettype none

package memb_pkg;

    // =========================================
    // Bus cycle states, one-hot
    typedef enum logic [5:0] {
        MEMB_IDLE  = 6'h01,
        MEMB_ADDR  = 6'h02,
        MEMB_LATCH = 6'h04,
        MEMB_DATA  = 6'h08,
        MEMB_END   = 6'h10,
        MEMB_ROM   = 6'h20
    } memb_state_e;

    // =========================================
    // Core request
    typedef struct packed {
        logic        write;
        logic        data_space;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } memb_req_s;

endpackage : memb_pkg

`default_nettype wire

// ===== src/memb_bus.sv
// External memory bus engine of the single-chip microcomputer
//
// How it works
// - The address strobe pulses low for one cycle at the start of each external machine cycle.
// - The address on the low port stays driven and stable across the strobe's rising edge.
// - The float input puts both strobes, read/write and both address ports in high impedance.
// - The data strobe goes low exactly once in each external transfer.
// - After reset release the block issues one boot fetch at address 000c.
// - Read/write is low while an external write cycle has its data strobe active.
// - Four 8-bit ports exist, the low and upper ones either general I/O or bus lines.
// - The 16-bit address reaches external program and data space over the multiplexed bus.
// - Program fetches below 2K are served by the on-chip ROM with no bus cycle.
// - Program fetches at 2048 and above, and all data accesses, run external cycles when the low port is a bus.
// - The upper port gives bits 8-11 on its low nibble or bits 8-15, as its mode says.
// - When enabled, port 3 line 4 shows whether a cycle targets data memory.
`include "memb_defines.svh"
`default_nettype none

module memb_bus (
    input  wire logic                     clk_sys,
    input  wire logic                     reset_n,
    input  wire logic                     req_valid,
    input  wire memb_pkg::memb_req_s      req,
    output var  logic                     req_ready_ff,
    output var  logic                     ack_ff,
    output var  logic [7:0]               rdata_ff,
    output var  logic                     boot_valid_ff,
    output var  logic [15:0]              boot_addr_ff,
    output var  logic [`MEMB_ROM_AW-1:0]  rom_addr_ff,
    input  wire logic [7:0]               rom_data,
    input  wire logic                     float_bus,
    input  wire logic                     low_port_ext,
    input  wire logic [1:0]               upper_mode,
    input  wire logic                     dm_enable,
    input  wire logic [7:0]               port0_gpio_out,
    input  wire logic [7:0]               port0_gpio_oe,
    input  wire logic [7:0]               port1_gpio_out,
    input  wire logic [7:0]               port1_gpio_oe,
    input  wire logic [7:0]               port2_gpio_out,
    input  wire logic [7:0]               port2_gpio_oe,
    input  wire logic [7:0]               port3_gpio_out,
    input  wire logic [7:0]               port3_gpio_oe,
    input  wire logic [7:0]               low_addr_data_port_in,
    output var  logic [7:0]               low_addr_data_port_out,
    output var  logic [7:0]               low_addr_data_port_oe,
    output var  logic [7:0]               upper_address_port_out,
    output var  logic [7:0]               upper_address_port_oe,
    output var  logic [7:0]               port2_out,
    output var  logic [7:0]               port2_oe,
    output var  logic [7:0]               port3_out,
    output var  logic [7:0]               port3_oe,
    output var  logic                     addr_strobe_n_out,
    output var  logic                     addr_strobe_n_oe,
    output var  logic                     data_strobe_n_out,
    output var  logic                     data_strobe_n_oe,
    output var  logic                     read_write_out,
    output var  logic                     read_write_oe
);

    // =========================================
    // Request decode and state
    memb_pkg::memb_state_e state_ff;
    memb_pkg::memb_state_e nxt_state;
    memb_pkg::memb_req_s   cur_ff;
    logic                  take;
    logic                  to_rom;
    logic                  drive_low;

    // Program fetch below the ROM limit stays on chip
    function automatic logic is_rom(input memb_pkg::memb_req_s r);
        is_rom = !r.data_space && !r.write && (r.addr < `MEMB_ROM_LIMIT);
    endfunction : is_rom

    assign to_rom = is_rom(req);
    // External only when the low port is a bus
    assign take   = req_valid && req_ready_ff && (to_rom || low_port_ext);

    // Next bus state
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            memb_pkg::MEMB_IDLE:
            begin
                if (take)
                    nxt_state = to_rom ? memb_pkg::MEMB_ROM : memb_pkg::MEMB_ADDR;
            end
            memb_pkg::MEMB_ADDR:  nxt_state = memb_pkg::MEMB_LATCH;
            memb_pkg::MEMB_LATCH: nxt_state = memb_pkg::MEMB_DATA;
            memb_pkg::MEMB_DATA:  nxt_state = memb_pkg::MEMB_END;
            memb_pkg::MEMB_END:   nxt_state = memb_pkg::MEMB_IDLE;
            memb_pkg::MEMB_ROM:   nxt_state = memb_pkg::MEMB_IDLE;
            default:              nxt_state = memb_pkg::MEMB_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            state_ff <= memb_pkg::MEMB_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Captured request
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            cur_ff <= '0;
        else if (take)
            cur_ff <= req;
    end

    // Ready only when idle and not floated
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            req_ready_ff <= 1'b0;
        else
            req_ready_ff <= (nxt_state == memb_pkg::MEMB_IDLE) && !float_bus;
    end

    // =========================================
    // Boot fetch after reset
    // One boot pulse at the start address
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            boot_valid_ff <= 1'b1;
            boot_addr_ff  <= `MEMB_BOOT_ADDR;
        end
        else
            boot_valid_ff <= 1'b0;
    end

    // =========================================
    // Answer to the core
    // ROM address from the request, data taken one cycle later
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            rom_addr_ff <= '0;
        else if (take && to_rom)
            rom_addr_ff <= req.addr[`MEMB_ROM_AW-1:0];
    end

    // Ack and read data
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ack_ff   <= 1'b0;
            rdata_ff <= '0;
        end
        else
        begin
            ack_ff <= (state_ff == memb_pkg::MEMB_DATA) || (state_ff == memb_pkg::MEMB_ROM);
            if (state_ff == memb_pkg::MEMB_ROM)
                rdata_ff <= rom_data;
            else if (state_ff == memb_pkg::MEMB_DATA && !cur_ff.write)
                rdata_ff <= low_addr_data_port_in;
        end
    end

    // =========================================
    // Strobes and read/write
    // Strobes follow the next state
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            addr_strobe_n_out <= 1'b1;
            data_strobe_n_out <= 1'b1;
        end
        else
        begin
            addr_strobe_n_out <= !(nxt_state == memb_pkg::MEMB_ADDR);
            data_strobe_n_out <= !(nxt_state == memb_pkg::MEMB_DATA);
        end
    end

    // Low only during a write data phase
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            read_write_out <= 1'b1;
        else
            read_write_out <= !((nxt_state == memb_pkg::MEMB_DATA) && cur_ff.write);
    end

    // Bus control drivers off while floated
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            addr_strobe_n_oe <= 1'b0;
            data_strobe_n_oe <= 1'b0;
            read_write_oe    <= 1'b0;
        end
        else
        begin
            addr_strobe_n_oe <= !float_bus;
            data_strobe_n_oe <= !float_bus;
            read_write_oe    <= !float_bus;
        end
    end

    // =========================================
    // Address/data and upper ports
    // Address phase, or write data phase
    assign drive_low = (nxt_state == memb_pkg::MEMB_ADDR) || (nxt_state == memb_pkg::MEMB_LATCH)
                       || ((nxt_state == memb_pkg::MEMB_DATA) && cur_ff.write);

    // Low port: address then data, or general I/O
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            low_addr_data_port_out <= '0;
            low_addr_data_port_oe  <= '0;
        end
        else if (!low_port_ext)
        begin
            low_addr_data_port_out <= port1_gpio_out;
            low_addr_data_port_oe  <= float_bus ? 8'h00 : port1_gpio_oe;
        end
        else
        begin
            if (take && !to_rom)
                low_addr_data_port_out <= req.addr[7:0];
            else if (nxt_state == memb_pkg::MEMB_DATA)
                low_addr_data_port_out <= cur_ff.wdata;
            low_addr_data_port_oe <= (drive_low && !float_bus) ? 8'hff : 8'h00;
        end
    end

    // Upper port: address bits 8-11 or 8-15, else general I/O
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            upper_address_port_out <= '0;
            upper_address_port_oe  <= '0;
        end
        else
        begin
            case (upper_mode)
                `MEMB_UP_NIBBLE:
                begin
                    upper_address_port_out <= {port0_gpio_out[7:4], cur_ff.addr[11:8]};
                    upper_address_port_oe  <= {port0_gpio_oe[7:4], 4'hf};
                end
                `MEMB_UP_FULL:
                begin
                    upper_address_port_out <= cur_ff.addr[15:8];
                    upper_address_port_oe  <= 8'hff;
                end
                default:
                begin
                    upper_address_port_out <= port0_gpio_out;
                    upper_address_port_oe  <= port0_gpio_oe;
                end
            endcase
            if (take && !to_rom && upper_mode != `MEMB_UP_IO)
                upper_address_port_out[3:0] <= req.addr[11:8];
            if (take && !to_rom && upper_mode == `MEMB_UP_FULL)
                upper_address_port_out[7:4] <= req.addr[15:12];
            if (float_bus)
                upper_address_port_oe <= 8'h00;
        end
    end

    // =========================================
    // Ports 2 and 3
    // General I/O, line 4 of port 3 may carry data space select
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            port2_out <= '0;
            port2_oe  <= '0;
            port3_out <= '0;
            port3_oe  <= '0;
        end
        else
        begin
            port2_out <= port2_gpio_out;
            port2_oe  <= port2_gpio_oe;
            port3_out <= port3_gpio_out;
            port3_oe  <= port3_gpio_oe;
            if (dm_enable)
            begin
                port3_out[`MEMB_DM_BIT] <= (take && !to_rom) ? req.data_space
                                                             : cur_ff.data_space;
                port3_oe[`MEMB_DM_BIT]  <= 1'b1;
            end
        end
    end

    // =========================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_cycle;
        $fell(addr_strobe_n_out) ##2 $fell(data_strobe_n_out) ##1 $rose(data_strobe_n_out);
    endsequence

    a_as_one_pulse: assert property ($fell(addr_strobe_n_out) |=> addr_strobe_n_out)
        else $error("address strobe low longer than one cycle");
    a_addr_at_rise: assert property (
        $rose(addr_strobe_n_out) && low_port_ext && !$past(float_bus)
        |-> $stable(low_addr_data_port_out) && low_addr_data_port_oe == 8'hff)
        else $error("address not held at strobe rise");
    a_float_all_off: assert property (float_bus |=> !addr_strobe_n_oe
        && !data_strobe_n_oe && !read_write_oe && low_addr_data_port_oe == 8'h00
        && upper_address_port_oe == 8'h00)
        else $error("bus not floated");
    a_ds_once: assert property ($fell(addr_strobe_n_out) |-> s_cycle)
        else $error("data strobe not once per cycle");
    a_boot_addr: assert property (boot_valid_ff
        |-> boot_addr_ff == `MEMB_BOOT_ADDR ##1 !boot_valid_ff)
        else $error("boot fetch wrong");
    a_write_low: assert property (!data_strobe_n_out && cur_ff.write |-> !read_write_out)
        else $error("read/write not low in write");
    a_rw_idle_high: assert property (!cur_ff.write || data_strobe_n_out
        |-> read_write_out)
        else $error("read/write low outside write");
    a_rom_no_bus: assert property (state_ff == memb_pkg::MEMB_ROM
        |-> addr_strobe_n_out && data_strobe_n_out ##1 ack_ff)
        else $error("ROM fetch touched the bus");
    a_dm_select: assert property (dm_enable && $fell(addr_strobe_n_out)
        |-> port3_out[`MEMB_DM_BIT] == cur_ff.data_space)
        else $error("data space select wrong");

endmodule : memb_bus

`default_nettype wire

// ===== test/memb_ext_mem.sv
// External program and data memory model for the bus bench
`default_nettype none

module memb_ext_mem (
    input  wire logic        clk_sys,
    input  wire logic        addr_strobe_n,
    input  wire logic        data_strobe_n,
    input  wire logic        read_write,
    input  wire logic [7:0]  lad_out,
    input  wire logic [7:0]  lad_oe,
    input  wire logic [7:0]  upper,
    output var  logic [7:0]  lad_pin,
    output var  logic [15:0] lat_addr,
    output var  logic [7:0]  wr_data
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] mem [0:65535];
    logic [7:0] junk = 8'h00;

    // =========================================
    // Contents seeded from the address
    initial
    begin
        lat_addr = 16'h0000;
        wr_data = 8'h00;
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
    end

    // =========================================
    // Released bits toggle so stale data never looks valid
    always @(posedge clk_sys)
        junk <= $isunknown(lad_pin) ? 8'h00 : ~lad_pin;

    // Wire level: device driver, then memory during a read strobe
    always @*
        for (int i = 0; i < 8; i++)
            lad_pin[i] = lad_oe[i] ? lad_out[i] :
                         (!data_strobe_n && read_write) ? mem[lat_addr][i] : junk[i];

    // Address latch on strobe rise
    always @(posedge addr_strobe_n)
        lat_addr <= {upper, lad_pin};

    // Write while read/write low
    always @(posedge clk_sys)
        if (!data_strobe_n && !read_write)
        begin
            mem[lat_addr] <= lad_pin;
            wr_data <= lad_pin;
        end
endmodule : memb_ext_mem

`default_nettype wire

// ===== test/tb_memb_bus.sv
// Self-checking bench for the external memory bus engine
`include "memb_defines.svh"
`default_nettype none

module tb_memb_bus;
    timeunit 1ns;
    timeprecision 1ns;

    // =========================================
    // Stimulus and observed signals
    logic clk_sys = 1'b0, reset_n = 1'b0, req_valid = 1'b0, float_bus = 1'b0;
    logic low_port_ext = 1'b1, dm_enable = 1'b0, rw_ds = 1'b1, dm_seen = 1'b0;
    logic [1:0] upper_mode = `MEMB_UP_FULL;
    memb_pkg::memb_req_s req = '0;
    logic [7:0] port0_gpio_out = 8'h00, port0_gpio_oe = 8'h00, port1_gpio_out = 8'h00;
    logic [7:0] port1_gpio_oe = 8'h00, port2_gpio_out = 8'h00, port2_gpio_oe = 8'h00;
    logic [7:0] port3_gpio_out = 8'h00, port3_gpio_oe = 8'h00, rom_data, rdata_ff, wr_data;
    logic [7:0] low_addr_data_port_in, low_addr_data_port_out, low_addr_data_port_oe;
    logic [7:0] upper_address_port_out, upper_address_port_oe;
    logic [7:0] port2_out, port2_oe, port3_out, port3_oe;
    logic [`MEMB_ROM_AW-1:0] rom_addr_ff;
    logic [15:0] boot_addr_ff, lat_addr;
    logic req_ready_ff, ack_ff, boot_valid_ff, addr_strobe_n_out, addr_strobe_n_oe;
    logic data_strobe_n_out, data_strobe_n_oe, read_write_out, read_write_oe;
    logic [31:0] seed = 32'h67cb;
    logic [7:0] shadow [logic [15:0]];
    int n_errors = 0, checks = 0, as_n = 0, ds_n = 0, rw_bad = 0, cyc = 0;

    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : pat

    function automatic logic [7:0] rpat(input logic [10:0] a);
        return a[7:0] ^ {5'h00, a[10:8]} ^ 8'ha5;
    endfunction : rpat

    function automatic logic [7:0] exp_up(input logic [15:0] a);
        return (upper_mode == `MEMB_UP_FULL) ? a[15:8] : {port0_gpio_out[7:4], a[11:8]};
    endfunction : exp_up

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // =========================================
    // Clock, on-chip ROM and instances
    always #25 clk_sys = ~clk_sys;
    assign rom_data = rpat(rom_addr_ff);

    memb_bus u_memb_bus (
        .clk_sys, .reset_n, .req_valid, .req, .req_ready_ff, .ack_ff, .rdata_ff,
        .boot_valid_ff, .boot_addr_ff, .rom_addr_ff, .rom_data, .float_bus, .low_port_ext,
        .upper_mode, .dm_enable, .port0_gpio_out, .port0_gpio_oe, .port1_gpio_out,
        .port1_gpio_oe, .port2_gpio_out, .port2_gpio_oe, .port3_gpio_out, .port3_gpio_oe,
        .low_addr_data_port_in, .low_addr_data_port_out, .low_addr_data_port_oe,
        .upper_address_port_out, .upper_address_port_oe, .port2_out, .port2_oe,
        .port3_out, .port3_oe, .addr_strobe_n_out, .addr_strobe_n_oe, .data_strobe_n_out,
        .data_strobe_n_oe, .read_write_out, .read_write_oe
    );

    // Strobes and read/write have board pull-ups
    memb_ext_mem u_memb_ext_mem (
        .clk_sys       (clk_sys),
        .addr_strobe_n (addr_strobe_n_oe ? addr_strobe_n_out : 1'b1),
        .data_strobe_n (data_strobe_n_oe ? data_strobe_n_out : 1'b1),
        .read_write    (read_write_oe ? read_write_out : 1'b1),
        .lad_out       (low_addr_data_port_out),
        .lad_oe        (low_addr_data_port_oe),
        .upper         (upper_address_port_out),
        .lad_pin       (low_addr_data_port_in),
        .lat_addr      (lat_addr),
        .wr_data       (wr_data)
    );

    // =========================================
    // Strobe counters, read/write watch and hang limit
    always @(posedge clk_sys)
    begin
        as_n <= as_n + int'(addr_strobe_n_out === 1'b0);
        ds_n <= ds_n + int'(data_strobe_n_out === 1'b0);
        if (data_strobe_n_out === 1'b0)
            rw_ds <= read_write_out;
        if (addr_strobe_n_out === 1'b0)
            dm_seen <= port3_out[4];
        if (data_strobe_n_out !== 1'b0 && read_write_oe === 1'b1 && read_write_out !== 1'b1)
            rw_bad <= rw_bad + 1;
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_errors++;
            conclude();
        end
    end

    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_v

    // One core request, waited on and checked against the memory map
    task automatic xfer(input logic w, d, input logic [15:0] a, input logic [7:0] wd);
        int k;
        int a0;
        int d0;
        logic ext;
        logic [15:0] seen;
        logic [7:0] exp;
        @(posedge clk_sys);
        ext = w | d | (a >= `MEMB_ROM_LIMIT);
        seen = {exp_up(a), a[7:0]};
        exp = !ext ? rpat(a[10:0]) : shadow.exists(seen) ? shadow[seen] : pat(seen);
        a0 = as_n;
        d0 = ds_n;
        k = 0;
        req <= '{w, d, a, wd};
        req_valid <= 1'b1;
        do @(negedge clk_sys); while (req_ready_ff !== 1'b1 && ++k < 50);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        k = 0;
        do @(negedge clk_sys); while (ack_ff !== 1'b1 && ++k < 50);
        chk_v(16'(k), ext ? 16'h0003 : 16'h0001);
        chk_v(16'(as_n - a0), {15'h0000, ext});
        chk_v(16'(ds_n - d0), {15'h0000, ext});
        if (!w)
            chk_v({8'h00, rdata_ff}, {8'h00, exp});
        if (ext)
            chk_v(lat_addr, seen);
        if (ext)
            chk_v({15'h0000, rw_ds}, {15'h0000, !w});
        if (ext && w)
            chk_v({8'h00, wr_data}, {8'h00, wd});
        if (ext && dm_enable)
            chk_v({15'h0000, dm_seen}, {15'h0000, d});
        if (ext && w)
            shadow[seen] = wd;
    endtask : xfer

    task automatic conclude();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    // =========================================
    // Main sequence
    initial
    begin
        logic [31:0] r;
        int a0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_v({boot_valid_ff, 15'h0000}, 16'h8000);
        chk_v(boot_addr_ff, `MEMB_BOOT_ADDR);
        chk_v({addr_strobe_n_out, data_strobe_n_out, read_write_out}, 16'h0007);
        chk_v({low_addr_data_port_oe, upper_address_port_oe}, 16'h0000);
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(negedge clk_sys);
        chk_v({boot_valid_ff, req_ready_ff}, 16'h0002);
        @(negedge clk_sys);
        chk_v({boot_valid_ff, req_ready_ff}, 16'h0001);
        $display("test reset done");
        xfer(1'b0, 1'b0, `MEMB_BOOT_ADDR, 8'h00);
        xfer(1'b0, 1'b0, 16'h07ff, 8'h00);
        xfer(1'b0, 1'b0, 16'h0800, 8'h00);
        xfer(1'b1, 1'b0, 16'hffff, 8'h3c);
        xfer(1'b0, 1'b0, 16'hffff, 8'h00);
        xfer(1'b0, 1'b1, 16'h0010, 8'h00);
        $display("test corners done");
        for (int i = 0; i < 60; i++)
        begin
            @(posedge clk_sys);
            r = rnd();
            port0_gpio_oe <= r[31:24];
            port1_gpio_out <= r[7:0];
            port1_gpio_oe <= r[15:8];
            upper_mode <= r[0] ? `MEMB_UP_FULL : `MEMB_UP_NIBBLE;
            dm_enable <= r[1];
            port0_gpio_out <= r[15:8];
            port2_gpio_out <= r[7:0];
            port2_gpio_oe <= r[23:16];
            xfer(r[2], r[3], {r[4] ? 5'h00 : r[31:27], r[26:16]}, r[23:16]);
        end
        $display("test random done");
        @(posedge clk_sys);
        low_port_ext <= 1'b0;
        upper_mode <= `MEMB_UP_IO;
        xfer(1'b0, 1'b0, 16'h0123, 8'h00);
        @(posedge clk_sys);
        a0 = as_n;
        req <= '{1'b0, 1'b0, 16'h0a00, 8'h00};
        req_valid <= 1'b1;
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_v(16'(as_n - a0), 16'h0000);
        chk_v({low_addr_data_port_out, upper_address_port_out},
              {port1_gpio_out, port0_gpio_out});
        chk_v({low_addr_data_port_oe, upper_address_port_oe},
              {port1_gpio_oe, port0_gpio_oe});
        @(posedge clk_sys);
        req_valid <= 1'b0;
        low_port_ext <= 1'b1;
        upper_mode <= `MEMB_UP_FULL;
        float_bus <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_v({addr_strobe_n_oe, data_strobe_n_oe, read_write_oe, req_ready_ff}, 16'h0000);
        chk_v({low_addr_data_port_oe, upper_address_port_oe}, 16'h0000);
        chk_v({port2_out, port2_oe}, {port2_gpio_out, port2_gpio_oe});
        @(posedge clk_sys);
        float_bus <= 1'b0;
        xfer(1'b1, 1'b1, 16'h0456, 8'h99);
        chk_v(16'(rw_bad), 16'h0000);
        $display("test float done");
        conclude();
    end
endmodule : tb_memb_bus

`default_nettype wire
